// file: src/igc_pkg.sv
// register offsets, field positions and reset values of the global id/config bank
// assumes an apb slave with 32-bit data and pprot[1] marking non-secure accesses
package igc_pkg;

  // ******************************
  // register offsets (byte addresses)
  // ******************************
  localparam logic [11:0] OFS_CAP1 = 12'h004;
  localparam logic [11:0] OFS_CAP2 = 12'h008;
  localparam logic [11:0] OFS_CAP3 = 12'h00c;
  localparam logic [11:0] OFS_CAP4 = 12'h010;
  localparam logic [11:0] OFS_CAP5 = 12'h014;
  localparam logic [11:0] OFS_CAP6 = 12'h018;
  localparam logic [11:0] OFS_CAP7 = 12'h01c;
  localparam logic [11:0] OFS_AUX = 12'h020;
  localparam logic [11:0] OFS_CFG0 = 12'h024;
  localparam logic [11:0] OFS_CFG0_ALIAS = 12'h028;
  localparam logic [11:0] OFS_AUX_ALIAS = 12'h02c;
  localparam logic [11:0] OFS_SCFG1 = 12'h030;

  // ******************************
  // capability word field positions
  // ******************************
  localparam int CAP1_PAGESZ_B = 31;
  localparam int CAP1_PGIDX_LSB = 28;
  localparam int CAP1_S2CB_LSB = 16;
  localparam int CAP1_CONFLICT_DET_B = 15;
  localparam int CAP1_SECTBL_B = 12;
  localparam int CAP1_SSDIDX_LSB = 8;
  localparam int CAP1_BANKS_LSB = 0;
  localparam int CAP2_OUTSZ_LSB = 4;
  localparam int CAP2_INSZ_LSB = 0;
  localparam int CAP7_MAJOR_LSB = 4;
  localparam int CAP7_MINOR_LSB = 0;

  // ******************************
  // configuration register 0 fields
  // ******************************
  localparam int CFG0_SECATTR_LSB = 28;
  localparam int CFG0_WALLOC_LSB = 26;
  localparam int CFG0_RALLOC_LSB = 24;
  localparam int CFG0_SHARE_LSB = 22;
  localparam int CFG0_CONFLICT_B = 21;
  localparam logic [31:0] CFG0_S_FIELDS = 32'h3fe00000;
  localparam logic [31:0] CFG0_NS_FIELDS = 32'h0fe00000;
  localparam logic [31:0] CFG0_CONFLICT_MASK = 32'h00200000;
  localparam logic [31:0] CFG0_RST = 32'h00000000;
  localparam logic [31:0] AUX_RST = 32'h00000000;
  localparam logic [31:0] SCFG1_FIELDS = 32'h000000ff;

  // ******************************
  // block state
  // ******************************
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] aux_s;
    logic [31:0] aux_ns;
    logic [31:0] cfg_s;
    logic [31:0] cfg_ns;
    logic [7:0] ns_limit;
  } igc_state_t;

endpackage

// file: src/igc_regs.sv
// global identification words and top-level bypass configuration, apb4 slave
// assumes a single clock, synchronous active-low reset, pprot[1]=1 for non-secure
`timescale 1ns/1ps
`default_nettype none

module igc_regs
  import igc_pkg::*;
#(
  parameter bit SEC_EXT = 1'b1,
  parameter bit PAGE_64K = 1'b0,
  parameter logic [2:0] PAGE_INDEX_BITS = 3'h0,
  parameter bit STAGE2_SUPPORTED = 1'b1,
  parameter logic [7:0] STAGE2_BANKS = 8'h00,
  parameter bit CONFLICT_DETECT = 1'b0,
  parameter bit SEC_TABLE_PRESENT = 1'b0,
  parameter logic [3:0] SEC_INDEX_BITS = 4'h0,
  parameter logic [7:0] BANK_COUNT = 8'h08,
  parameter logic [3:0] OUT_ADDR_SIZE = 4'h0,
  parameter logic [3:0] IN_ADDR_SIZE = 4'h0,
  parameter logic [3:0] VER_MAJOR = 4'h1,
  parameter logic [3:0] VER_MINOR = 4'h0,
  parameter logic [31:0] IMPL_CAP4 = 32'h00000000,
  parameter logic [31:0] IMPL_CAP5 = 32'h00000000,
  parameter bit CONFLICT_FIXED = 1'b0,
  parameter bit CONFLICT_FIXED_VAL = 1'b0
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [2:0] pprot_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [1:0] s_bypass_security_attr_out,
  output logic [1:0] s_bypass_write_alloc_out,
  output logic [1:0] s_bypass_read_alloc_out,
  output logic [1:0] s_bypass_shareability_out,
  output logic s_conflict_fault_select_out,
  output logic [1:0] ns_bypass_write_alloc_out,
  output logic [1:0] ns_bypass_read_alloc_out,
  output logic [1:0] ns_bypass_shareability_out,
  output logic ns_conflict_fault_select_out,
  output logic [31:0] aux_s_out,
  output logic [31:0] aux_ns_out
);

  // ******************************
  // reset state, write masks and capability word builders
  // ******************************
  localparam logic [31:0] CFG0_RST_V = CFG0_RST | (CONFLICT_FIXED_VAL ? CFG0_CONFLICT_MASK : 32'h00000000);
  // a fixed conflict bit is simply kept out of the write mask
  localparam logic [31:0] CFG0_S_WMASK = CONFLICT_FIXED ? (CFG0_S_FIELDS & ~CFG0_CONFLICT_MASK) : CFG0_S_FIELDS;
  localparam logic [31:0] CFG0_NS_WMASK = CONFLICT_FIXED ? (CFG0_NS_FIELDS & ~CFG0_CONFLICT_MASK) : CFG0_NS_FIELDS;
  localparam igc_state_t ST_RST = '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000,
                                    aux_s: AUX_RST, aux_ns: AUX_RST, cfg_s: CFG0_RST_V,
                                    cfg_ns: CFG0_RST_V, ns_limit: BANK_COUNT};

  function automatic logic [31:0] cap1_word(input logic ns_view, input logic [7:0] ns_limit);
    logic [31:0] v;
    v = 32'h00000000;
    v[CAP1_PAGESZ_B] = PAGE_64K;
    v[CAP1_PGIDX_LSB +: 3] = PAGE_INDEX_BITS;
    v[CAP1_S2CB_LSB +: 8] = STAGE2_SUPPORTED ? STAGE2_BANKS : 8'h00;
    v[CAP1_CONFLICT_DET_B] = CONFLICT_DETECT;
    v[CAP1_SECTBL_B] = SEC_TABLE_PRESENT & ~ns_view;
    v[CAP1_SSDIDX_LSB +: 4] = (SEC_TABLE_PRESENT & ~ns_view) ? SEC_INDEX_BITS : 4'h0;
    v[CAP1_BANKS_LSB +: 8] = ns_view ? ns_limit : BANK_COUNT;
    return v;
  endfunction

  function automatic logic [31:0] cap2_word();
    logic [31:0] v;
    v = 32'h00000000;
    v[CAP2_OUTSZ_LSB +: 4] = OUT_ADDR_SIZE;
    v[CAP2_INSZ_LSB +: 4] = IN_ADDR_SIZE;
    return v;
  endfunction

  function automatic logic [31:0] cap7_word();
    logic [31:0] v;
    v = 32'h00000000;
    v[CAP7_MAJOR_LSB +: 4] = VER_MAJOR;
    v[CAP7_MINOR_LSB +: 4] = VER_MINOR;
    return v;
  endfunction

  // byte strobes and the field mask together decide which bits a write touches
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    return (old & ~m) | (wd & m);
  endfunction

  // ******************************
  // state and apb decode
  // ******************************
  igc_state_t st_r;
  igc_state_t st_nxt;
  logic [11:0] word_addr;
  logic ns_view;
  logic ns_bank;
  logic setup;
  logic wr_fire;

  assign word_addr = {paddr_in[11:2], 2'b00};
  // without security support there is a single bank and no secure-only registers
  assign ns_view = SEC_EXT & pprot_in[1];
  assign ns_bank = ~SEC_EXT | pprot_in[1];
  assign setup = psel_in & ~penable_in;
  assign wr_fire = psel_in & penable_in & pwrite_in & st_r.pready;

  always_comb begin
    logic hit;
    logic [31:0] rd;
    logic [31:0] lim_w;
    hit = 1'b1;
    lim_w = wmerge({24'h000000, st_r.ns_limit}, pwdata_in, pstrb_in, SCFG1_FIELDS);
    rd = 32'h00000000;
    st_nxt = st_r;
    // zero-wait slave: ready for exactly the first access cycle
    st_nxt.pready = setup;
    unique case (word_addr)
      OFS_CAP1: rd = cap1_word(ns_view, st_r.ns_limit);
      OFS_CAP2: rd = cap2_word();
      OFS_CAP3: rd = 32'h00000000;
      OFS_CAP4: rd = IMPL_CAP4;
      OFS_CAP5: rd = IMPL_CAP5;
      OFS_CAP6: rd = 32'h00000000;
      OFS_CAP7: rd = cap7_word();
      OFS_AUX: rd = ns_bank ? st_r.aux_ns : st_r.aux_s;
      OFS_CFG0: rd = ns_bank ? st_r.cfg_ns : st_r.cfg_s;
      OFS_CFG0_ALIAS: begin
        hit = ~ns_bank;
        rd = ns_bank ? 32'h00000000 : st_r.cfg_ns;
      end
      OFS_AUX_ALIAS: begin
        hit = ~ns_bank;
        rd = ns_bank ? 32'h00000000 : st_r.aux_ns;
      end
      OFS_SCFG1: begin
        hit = ~ns_bank;
        rd = ns_bank ? 32'h00000000 : {24'h000000, st_r.ns_limit};
      end
      default: begin
        hit = 1'b0;
        rd = 32'h00000000;
      end
    endcase
    if (setup) begin
      st_nxt.prdata = pwrite_in ? 32'h00000000 : rd;
      st_nxt.pslverr = ~hit;
    end
    // capability words have no write path at all
    if (wr_fire && hit) begin
      unique case (word_addr)
        OFS_AUX: begin
          if (ns_bank) begin
            st_nxt.aux_ns = wmerge(st_r.aux_ns, pwdata_in, pstrb_in, 32'hffffffff);
          end else begin
            st_nxt.aux_s = wmerge(st_r.aux_s, pwdata_in, pstrb_in, 32'hffffffff);
          end
        end
        OFS_CFG0: begin
          if (ns_bank) begin
            st_nxt.cfg_ns = wmerge(st_r.cfg_ns, pwdata_in, pstrb_in, CFG0_NS_WMASK);
          end else begin
            st_nxt.cfg_s = wmerge(st_r.cfg_s, pwdata_in, pstrb_in, CFG0_S_WMASK);
          end
        end
        OFS_CFG0_ALIAS: st_nxt.cfg_ns = wmerge(st_r.cfg_ns, pwdata_in, pstrb_in, CFG0_NS_WMASK);
        OFS_AUX_ALIAS: st_nxt.aux_ns = wmerge(st_r.aux_ns, pwdata_in, pstrb_in, 32'hffffffff);
        OFS_SCFG1: st_nxt.ns_limit = lim_w[7:0];
        default: st_nxt.prdata = st_r.prdata;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ******************************
  // outputs
  // ******************************
  assign prdata_out = st_r.prdata;
  assign pready_out = st_r.pready;
  assign pslverr_out = st_r.pslverr;
  assign s_bypass_security_attr_out = st_r.cfg_s[CFG0_SECATTR_LSB +: 2];
  assign s_bypass_write_alloc_out = st_r.cfg_s[CFG0_WALLOC_LSB +: 2];
  assign s_bypass_read_alloc_out = st_r.cfg_s[CFG0_RALLOC_LSB +: 2];
  assign s_bypass_shareability_out = st_r.cfg_s[CFG0_SHARE_LSB +: 2];
  assign s_conflict_fault_select_out = st_r.cfg_s[CFG0_CONFLICT_B];
  assign ns_bypass_write_alloc_out = st_r.cfg_ns[CFG0_WALLOC_LSB +: 2];
  assign ns_bypass_read_alloc_out = st_r.cfg_ns[CFG0_RALLOC_LSB +: 2];
  assign ns_bypass_shareability_out = st_r.cfg_ns[CFG0_SHARE_LSB +: 2];
  assign ns_conflict_fault_select_out = st_r.cfg_ns[CFG0_CONFLICT_B];
  assign aux_s_out = st_r.aux_s;
  assign aux_ns_out = st_r.aux_ns;

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rd(logic [11:0] ofs, logic nsb);
    psel_in && !penable_in && !pwrite_in && (word_addr == ofs) && (pprot_in[1] == nsb);
  endsequence

  sequence s_wr(logic [11:0] ofs, logic nsb);
    psel_in && !penable_in && pwrite_in && (word_addr == ofs) && (pprot_in[1] == nsb) && (pstrb_in == 4'hf)
    ##1 psel_in && penable_in && pready_out;
  endsequence

  property p_cap1_secure;
    s_rd(OFS_CAP1, 1'b0) |=> prdata_out[31:28] == {PAGE_64K, PAGE_INDEX_BITS} && !pslverr_out;
  endproperty
  a_cap1_secure: assert property (p_cap1_secure) else $error("page size or index field wrong");

  property p_context_bank_count_ns;
    s_rd(OFS_CAP1, 1'b1) |=> prdata_out[7:0] == (SEC_EXT ? $past(st_r.ns_limit) : BANK_COUNT);
  endproperty
  a_context_bank_count_ns: assert property (p_context_bank_count_ns) else $error("non-secure bank count not the limit");

  property p_ssd_raz_ns;
    s_rd(OFS_CAP1, 1'b1) |=> !SEC_EXT || prdata_out[12:8] == 5'h00;
  endproperty
  a_ssd_raz_ns: assert property (p_ssd_raz_ns) else $error("security table bits visible to non-secure");

  property p_cap2;
    s_rd(OFS_CAP2, 1'b0) |=> prdata_out == {24'h000000, OUT_ADDR_SIZE, IN_ADDR_SIZE};
  endproperty
  a_cap2: assert property (p_cap2) else $error("address size word wrong");

  property p_cap3_rsvd;
    s_rd(OFS_CAP3, 1'b0) |=> prdata_out == 32'h00000000 && !pslverr_out;
  endproperty
  a_cap3_rsvd: assert property (p_cap3_rsvd) else $error("reserved word not zero");

  property p_cap7;
    s_rd(OFS_CAP7, 1'b0) |=> prdata_out == {24'h000000, VER_MAJOR, VER_MINOR};
  endproperty
  a_cap7: assert property (p_cap7) else $error("version word wrong");

  property p_ns_no_secure_ctl;
    s_wr(OFS_CFG0, 1'b1) |=> $stable(st_r.cfg_s);
  endproperty
  a_ns_no_secure_ctl: assert property (p_ns_no_secure_ctl) else $error("non-secure write changed secure copy");

  property p_walloc_write;
    s_wr(OFS_CFG0, 1'b0) |=> !SEC_EXT || s_bypass_write_alloc_out == $past(pwdata_in[27:26]);
  endproperty
  a_walloc_write: assert property (p_walloc_write) else $error("write-allocate hint not stored");

  property p_alias_write;
    s_wr(OFS_CFG0_ALIAS, 1'b0) |=> !SEC_EXT || ns_bypass_shareability_out == $past(pwdata_in[23:22]);
  endproperty
  a_alias_write: assert property (p_alias_write) else $error("alias write missed non-secure copy");

  property p_aux_roundtrip;
    s_wr(OFS_AUX, 1'b0) |=> aux_s_out == $past(pwdata_in) || !SEC_EXT;
  endproperty
  a_aux_roundtrip: assert property (p_aux_roundtrip) else $error("auxiliary write lost");

  property p_cfg_rsvd;
    ((st_r.cfg_s & ~CFG0_S_FIELDS) == 32'h00000000) && ((st_r.cfg_ns & ~CFG0_NS_FIELDS) == 32'h00000000);
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("reserved configuration bit set");

  property p_conflict_fixed;
    !CONFLICT_FIXED || (s_conflict_fault_select_out == CONFLICT_FIXED_VAL);
  endproperty
  a_conflict_fixed: assert property (p_conflict_fixed) else $error("fixed conflict bit moved");

  property p_stage2_count;
    s_rd(OFS_CAP1, 1'b0) |=> prdata_out[23:16] == (STAGE2_SUPPORTED ? STAGE2_BANKS : 8'h00);
  endproperty
  a_stage2_count: assert property (p_stage2_count) else $error("stage 2 bank count wrong");

  property p_bank_total;
    s_rd(OFS_CAP1, 1'b0) |=> prdata_out[7:0] == BANK_COUNT;
  endproperty
  a_bank_total: assert property (p_bank_total) else $error("secure bank total wrong");

  property p_conflict_detect;
    s_rd(OFS_CAP1, 1'b0) |=> prdata_out[15] == CONFLICT_DETECT;
  endproperty
  a_conflict_detect: assert property (p_conflict_detect) else $error("conflict detect bit wrong");

  property p_ns_alias_refused;
    s_rd(OFS_CFG0_ALIAS, 1'b1) |=> !SEC_EXT || (pslverr_out && prdata_out == 32'h00000000);
  endproperty
  a_ns_alias_refused: assert property (p_ns_alias_refused) else $error("alias open to non-secure");

  property p_secattr_write;
    s_wr(OFS_CFG0, 1'b0) |=> !SEC_EXT || s_bypass_security_attr_out == $past(pwdata_in[29:28]);
  endproperty
  a_secattr_write: assert property (p_secattr_write) else $error("security attribute not stored");

  property p_ralloc_write;
    s_wr(OFS_CFG0, 1'b0) |=> !SEC_EXT || s_bypass_read_alloc_out == $past(pwdata_in[25:24]);
  endproperty
  a_ralloc_write: assert property (p_ralloc_write) else $error("read-allocate hint not stored");

  property p_share_write;
    s_wr(OFS_CFG0, 1'b0) |=> !SEC_EXT || s_bypass_shareability_out == $past(pwdata_in[23:22]);
  endproperty
  a_share_write: assert property (p_share_write) else $error("shareability not stored");

  property p_conflict_write;
    s_wr(OFS_CFG0, 1'b0) |=> !SEC_EXT ||
      s_conflict_fault_select_out == (CONFLICT_FIXED ? CONFLICT_FIXED_VAL : $past(pwdata_in[21]));
  endproperty
  a_conflict_write: assert property (p_conflict_write) else $error("conflict select not stored");

endmodule

`default_nettype wire

// file: test/igc_regs_tb.sv
// self-checking bench for the global id/config register bank
// assumes igc_regs alone, apb master and monitor both live here
`timescale 1ns/1ps
`default_nettype none
module iommu_global_id_config_regs_tb;
  import igc_pkg::*;
  // ********
  // signals and expected words
  // ********
  localparam logic TB_PAGE_64K = 1'b1;
  localparam logic [2:0] TB_PAGE_IDX = 3'h2;
  localparam logic [7:0] TB_S2_BANKS = 8'h03;
  localparam logic TB_CONFLICT_DET = 1'b1;
  localparam logic TB_SEC_TABLE = 1'b1;
  localparam logic [3:0] TB_SEC_IDX = 4'h5;
  localparam logic [7:0] TB_BANKS = 8'h10;
  localparam logic [3:0] TB_OUT_SIZE = 4'h1;
  localparam logic [3:0] TB_IN_SIZE = 4'h2;
  localparam logic [3:0] TB_VER_MAJOR = 4'h3;
  localparam logic [3:0] TB_VER_MINOR = 4'h4;
  localparam logic [31:0] CAP1_S = {TB_PAGE_64K, TB_PAGE_IDX, 4'h0, TB_S2_BANKS, TB_CONFLICT_DET, 2'b00,
                                    TB_SEC_TABLE, TB_SEC_IDX, TB_BANKS};
  localparam logic [31:0] CAP1_NS = {TB_PAGE_64K, TB_PAGE_IDX, 4'h0, TB_S2_BANKS, TB_CONFLICT_DET, 2'b00,
                                     1'b0, 4'h0, TB_BANKS};
  localparam logic [31:0] CAP2_V = {24'h000000, TB_OUT_SIZE, TB_IN_SIZE};
  localparam logic [31:0] CAP7_V = {24'h000000, TB_VER_MAJOR, TB_VER_MINOR};
  // implementation words: arbitrary values
  localparam logic [31:0] IMPL4 = 32'h5a5a0001;
  localparam logic [31:0] IMPL5 = 32'h00c30102;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0] pstrb_in = 4'h0;
  logic [2:0] pprot_in = 3'h0;
  logic [31:0] prdata_out, aux_s_out, aux_ns_out, r1, r2;
  logic pready_out, pslverr_out, s_cf, ns_cf;
  logic [1:0] s_sa, s_wa, s_ra, s_sh, ns_wa, ns_ra, ns_sh;
  logic [32:0] exp_q[$];
  logic [32:0] exp_v;
  logic [31:0] cap_s[7] = '{CAP1_S, CAP2_V, 32'h0, IMPL4, IMPL5, 32'h0, CAP7_V};
  logic [31:0] cap_ns[7] = '{CAP1_NS, CAP2_V, 32'h0, IMPL4, IMPL5, 32'h0, CAP7_V};
  logic [1:0] c;
  int err_count = 0;
  int checks = 0;

  always #25 mclk_in = ~mclk_in;

  igc_regs #(.PAGE_64K(TB_PAGE_64K), .PAGE_INDEX_BITS(TB_PAGE_IDX), .STAGE2_BANKS(TB_S2_BANKS),
    .CONFLICT_DETECT(TB_CONFLICT_DET), .SEC_TABLE_PRESENT(TB_SEC_TABLE), .SEC_INDEX_BITS(TB_SEC_IDX),
    .BANK_COUNT(TB_BANKS), .OUT_ADDR_SIZE(TB_OUT_SIZE), .IN_ADDR_SIZE(TB_IN_SIZE), .VER_MAJOR(TB_VER_MAJOR),
    .VER_MINOR(TB_VER_MINOR), .IMPL_CAP4(IMPL4), .IMPL_CAP5(IMPL5)) i_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .pprot_in(pprot_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .s_bypass_security_attr_out(s_sa), .s_bypass_write_alloc_out(s_wa), .s_bypass_read_alloc_out(s_ra),
    .s_bypass_shareability_out(s_sh), .s_conflict_fault_select_out(s_cf),
    .ns_bypass_write_alloc_out(ns_wa), .ns_bypass_read_alloc_out(ns_ra),
    .ns_bypass_shareability_out(ns_sh), .ns_conflict_fault_select_out(ns_cf),
    .aux_s_out(aux_s_out), .aux_ns_out(aux_ns_out));

  // ********
  // apb master, monitor and compares
  // ********
  function automatic logic [31:0] cfg_vec();
    return {16'h0, s_sa, s_wa, s_ra, s_sh, s_cf, ns_wa, ns_ra, ns_sh, ns_cf};
  endfunction

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
    report(got[31:0], exp[31:0]);
    report({31'h0, got[32]}, {31'h0, exp[32]});
  endtask

  task automatic chk_lvl(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask

  // request stays up until pready is seen; release is left to idle so back-to-back is legal
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic ns,
                     input logic [3:0] st, input logic [31:0] ed, input logic ee);
    int n;
    n = 0;
    exp_q.push_back({ee, ed});
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= st;
    pprot_in <= {1'($urandom), ns, 1'($urandom)};
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    if (pready_out !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %0t no ready within the wait limit", $time);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic ns, input logic [31:0] ed, input logic ee);
    apb(1'b0, a, 32'h0, ns, 4'hf, ed, ee);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ns, input logic [3:0] st,
                    input logic ee);
    apb(1'b1, a, d, ns, st, 32'h0, ee);
  endtask

  task automatic idle();
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  always @(posedge mclk_in) begin
    if (psel_in && penable_in && pready_out === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
      chk_rd({pslverr_out, prdata_out}, exp_v);
    end
  end

  task automatic close_out();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk_in);
    err_count++;
    close_out();
  end

  // ********
  // scenarios
  // ********
  initial begin
    void'($urandom(32'h2e75));
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    chk_lvl(cfg_vec(), 32'h0);
    chk_lvl(aux_s_out | aux_ns_out, 32'h0);
    // every id word in both views, then a write that must not stick
    for (int i = 0; i < 7; i++) begin
      rd(OFS_CAP1 + 12'(4 * i), 1'b0, cap_s[i], 1'b0);
      rd(OFS_CAP1 + 12'(4 * i), 1'b1, cap_ns[i], 1'b0);
      wr(OFS_CAP1 + 12'(4 * i), 32'hffffffff, 1'b0, 4'hf, 1'b0);
      rd(OFS_CAP1 + 12'(4 * i), 1'b0, cap_s[i], 1'b0);
    end
    wr(OFS_CFG0, 32'hffffffff, 1'b0, 4'hf, 1'b0);
    rd(OFS_CFG0, 1'b0, 32'h3fe00000, 1'b0);
    idle();
    chk_lvl(cfg_vec(), 32'hff80);
    wr(OFS_CFG0, 32'hffffffff, 1'b1, 4'hf, 1'b0);
    rd(OFS_CFG0, 1'b1, 32'h0fe00000, 1'b0);
    rd(OFS_CFG0_ALIAS, 1'b0, 32'h0fe00000, 1'b0);
    rd(OFS_CFG0_ALIAS, 1'b1, 32'h0, 1'b1);
    idle();
    chk_lvl(cfg_vec(), 32'hffff);
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      wr(OFS_CFG0, {2'b00, c, c, c, c, c[0], 21'h0}, 1'b0, 4'hf, 1'b0);
      idle();
      chk_lvl(cfg_vec() >> 7, {23'h0, c, c, c, c, c[0]});
    end
    // partial strobe: only the top byte keeps its value
    wr(OFS_CFG0, 32'h0, 1'b0, 4'b0111, 1'b0);
    idle();
    chk_lvl(cfg_vec() >> 7, {23'h0, 2'h3, 2'h3, 2'h3, 2'h0, 1'b0});
    r1 = $urandom;
    r2 = $urandom;
    wr(OFS_AUX, r1, 1'b0, 4'hf, 1'b0);
    wr(OFS_AUX, r2, 1'b1, 4'hf, 1'b0);
    rd(OFS_AUX, 1'b0, r1, 1'b0);
    rd(OFS_AUX, 1'b1, r2, 1'b0);
    rd(OFS_AUX_ALIAS, 1'b0, r2, 1'b0);
    wr(OFS_AUX_ALIAS, ~r2, 1'b0, 4'b1000, 1'b0);
    rd(OFS_AUX, 1'b1, {~r2[31:24], r2[23:0]}, 1'b0);
    idle();
    chk_lvl(aux_s_out, r1);
    // secure limit shapes what non-secure software sees as the bank count
    rd(OFS_SCFG1, 1'b0, 32'h10, 1'b0);
    wr(OFS_SCFG1, 32'hffffff05, 1'b0, 4'hf, 1'b0);
    rd(OFS_CAP1, 1'b1, {CAP1_NS[31:8], 8'h05}, 1'b0);
    rd(OFS_CAP1, 1'b0, CAP1_S, 1'b0);
    wr(OFS_SCFG1, 32'h0, 1'b1, 4'hf, 1'b1);
    rd(12'h0fc, 1'b0, 32'h0, 1'b1);
    wr(12'h0fc, 32'hffffffff, 1'b0, 4'hf, 1'b1);
    idle();
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    chk_lvl(cfg_vec(), 32'h0);
    chk_lvl(aux_s_out | aux_ns_out, 32'h0);
    rd(OFS_CAP1, 1'b1, CAP1_NS, 1'b0);
    idle();
    idle();
    close_out();
  end
endmodule
`default_nettype wire
